// ==== crs_regs.vh ====
// Constants for the card response and status block.
// Included by the status block design file only (the CRC7 file does not include it); definitions only.
`ifndef CRS_REGS_VH
`define CRS_REGS_VH

// Frame layout on the command line
`define CRS_FRAME_BITS 48
`define CRS_CRC_START 40
`define CRS_LAST_BIT 6'd47
`define CRS_CRC_FIRST 6'd40
`define CRS_CRC_FEED_END 6'd40
`define CRS_CNT_W 6

// Command and response field values
`define CRS_IDX_IFCOND 6'h08
`define CRS_R7_RSVD 20'h00000
`define CRS_CRC_PAD 7'h00

// Accepted-voltage codes
`define CRS_VOLT_UNDEF 4'h0
`define CRS_VOLT_HIGH 4'h1
`define CRS_VOLT_LOW 4'h2
`define CRS_VOLT_RSV4 4'h4
`define CRS_VOLT_RSV8 4'h8

// Status bit positions within the upper half (bit 31 is index 15)
`define CRS_B_ARG_RANGE 15
`define CRS_B_ADDR 14
`define CRS_B_BLK_LEN 13
`define CRS_B_ERASE_ORD 12
`define CRS_B_ERASE_SEL 11
`define CRS_B_PROT_WR 10
`define CRS_B_LOCKED 9
`define CRS_B_LOCK_FAIL 8
`define CRS_B_CMD_CRC 7
`define CRS_B_BAD_CMD 6
`define CRS_B_ECC_FAIL 5
`define CRS_B_CTRL 4
`define CRS_B_GENERAL 3
`define CRS_B_RSV18 2
`define CRS_B_RSV17 1
`define CRS_B_SPEC_OVR 0

// Clear classes of the upper status half
`define CRS_CLR_READ_MASK 16'hfd39
`define CRS_CLR_NEXT_MASK 16'h00c0
`define CRS_STAT_RESET 16'h0000

// Bus clock falling edges between command end and response start
`define CRS_NCR_EDGES 3'd2

`endif

// ==== crs_crc7.v ====
// Serial CRC7 generator, polynomial x^7 + x^3 + 1.
// Assumes the caller feeds one bit per step, MSB first.
module crs_crc7 (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Feed
  input wire step_i,
  input wire first_i,
  input wire bit_i,
  // Result
  output reg [6:0] crc_o
);

  wire [6:0] base;
  wire fb;

  // First bit of a frame starts from zero without a separate clear cycle
  assign base = first_i ? 7'h00 : crc_o;
  assign fb = bit_i ^ base[6];

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_o <= 7'h00;
    end else if (ce_i && step_i) begin
      crc_o <= {base[5:3], base[2] ^ fb, base[1:0], fb};
    end
  end

endmodule // crs_crc7

// ==== crs_card_status.v ====
// Card-side command receiver, interface-condition and normal responder, and card status word.
// Assumes the bus clock and command line come from the host pins; error events come from
// card logic on ref_clk_i as one-cycle pulses, the lock state as a level.
`include "crs_regs.vh"

// Operation
// R1 - Interface-condition reply is fixed 48-bit frame
// R2 - Accepted voltage code sits in bits 19-16
// R3 - Reply only when offered voltage is accepted
// R4 - Echo voltage and check pattern unchanged
// R5 - Voltage code 0001b means 2.7-3.6V
// R6 - Normal replies carry 32-bit status field
// R7 - Status refers to the previous command
// R8 - Reply-time and execution-time bits set separately
// R9 - Host polls status command for execution bits
// R10 - Next-clear bits drop after next valid command
// R11 - Bit 31 argument arg_range_err, clear-on-read
// R12 - Bit 30 misaligned address, clear-on-read
// R13 - Bit 29 block length error, clear-on-read
// R14 - Bit 28 erase order error, clear-on-read
// R15 - Bit 27 erase selection error, clear-on-read
// R16 - Bit 26 protected block write, clear-on-read
// R17 - Bit 25 follows current lock state
// R18 - Bit 24 lock or unlock failure, clear-on-read
// R19 - Bit 23 command CRC failure, next-clear
// R20 - Bit 22 bad_cmd_err, next-clear
// R21 - Bits 21,20,19 ECC, controller, general errors
// R22 - Bit 16 specific-data overwrite, clear-on-read
// R23 - Reserved bits 18 and 17 read zero
module crs_card_status #(
  parameter [3:0] SUPPORTED_VOLT = `CRS_VOLT_HIGH
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Card bus pins
  input wire bus_clk_i,
  input wire cmd_i,
  output reg cmd_o,
  output reg cmd_oe_o,
  // Card logic: command decode
  input wire cmd_illegal_i,
  input wire [15:0] status_lo_i,
  output reg cmd_valid_o,
  output reg [5:0] cmd_index_o,
  output reg [31:0] cmd_arg_o,
  // Card logic: status events
  input wire arg_range_err_i,
  input wire addr_err_i,
  input wire blk_length_err_i,
  input wire erase_order_err_i,
  input wire erase_select_err_i,
  input wire protected_write_err_i,
  input wire locked_flag_i,
  input wire lock_fail_err_i,
  input wire ecc_fail_err_i,
  input wire controller_err_i,
  input wire general_err_i,
  input wire specific_data_overwrite_err_i,
  output reg [31:0] card_status_word_o
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RX = 3'd1;
  localparam [2:0] S_CHK = 3'd2;
  localparam [2:0] S_WAIT = 3'd3;
  localparam [2:0] S_TX = 3'd4;

  reg bclk_s1_reg, bclk_s2_reg, bclk_d_reg;
  reg cmd_s1_reg, cmd_s2_reg;
  reg [2:0] state_reg;
  reg [`CRS_CNT_W-1:0] cnt_reg;
  reg [`CRS_FRAME_BITS-1:0] sr_reg;
  reg [2:0] gap_reg;
  reg [15:0] stat_reg;
  wire [15:0] stat_next;
  reg [15:0] clr_vec;
  reg crc_step, crc_first, crc_bit;
  wire [6:0] crc_val;
  wire bclk_rise, bclk_fall;
  wire [`CRS_CNT_W-1:0] cnt_inc;
  wire [15:0] set_vec;
  wire [5:0] rx_index;
  wire [31:0] rx_arg;
  wire rx_crc_ok, rx_from_host, volt_ok;
  wire frame_good, frame_bad, cmd_legal, send_r7, send_r1;
  wire [`CRS_FRAME_BITS-1:0] r1_frame, r7_frame;

  // Pins are asynchronous to ref_clk_i; only the second stage and its bclk_d_reg copy are looked at
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      cmd_s1_reg <= 1'b1;
      cmd_s2_reg <= 1'b1;
    end else if (ce_i) begin
      bclk_s1_reg <= bus_clk_i;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_d_reg <= bclk_s2_reg;
      cmd_s1_reg <= cmd_i;
      cmd_s2_reg <= cmd_s1_reg;
    end
  end

  assign bclk_rise = bclk_s2_reg & ~bclk_d_reg;
  assign bclk_fall = ~bclk_s2_reg & bclk_d_reg;
  assign cnt_inc = cnt_reg + 6'd1;

  // Received frame fields
  assign rx_index = sr_reg[45:40];
  assign rx_arg = sr_reg[39:8];
  assign rx_from_host = sr_reg[46];
  assign rx_crc_ok = (crc_val == sr_reg[7:1]) && sr_reg[0];
  assign frame_good = rx_from_host && rx_crc_ok;
  assign frame_bad = rx_from_host && !rx_crc_ok;
  assign cmd_legal = frame_good && !cmd_illegal_i;
  assign volt_ok = (rx_arg[11:8] == SUPPORTED_VOLT); // R5
  assign send_r7 = cmd_legal && (rx_index == `CRS_IDX_IFCOND) && volt_ok; // R3
  assign send_r1 = cmd_legal && (rx_index != `CRS_IDX_IFCOND);

  // Reply frames, CRC field filled in while shifting out
  assign r7_frame = {1'b0, 1'b0, `CRS_IDX_IFCOND, `CRS_R7_RSVD, rx_arg[11:8], rx_arg[7:0],
                     `CRS_CRC_PAD, 1'b1}; // R1 R2 R4
  assign r1_frame = {1'b0, 1'b0, rx_index, stat_reg, status_lo_i, `CRS_CRC_PAD, 1'b1}; // R6 R7

  // Event sources per status bit; reserved and lock positions never latch
  assign set_vec[`CRS_B_ARG_RANGE] = arg_range_err_i; // R11
  assign set_vec[`CRS_B_ADDR] = addr_err_i; // R12
  assign set_vec[`CRS_B_BLK_LEN] = blk_length_err_i; // R13
  assign set_vec[`CRS_B_ERASE_ORD] = erase_order_err_i; // R14
  assign set_vec[`CRS_B_ERASE_SEL] = erase_select_err_i; // R15
  assign set_vec[`CRS_B_PROT_WR] = protected_write_err_i; // R16
  assign set_vec[`CRS_B_LOCKED] = 1'b0;
  assign set_vec[`CRS_B_LOCK_FAIL] = lock_fail_err_i; // R18
  assign set_vec[`CRS_B_CMD_CRC] = (state_reg == S_CHK) && frame_bad; // R19 R8
  assign set_vec[`CRS_B_BAD_CMD] = (state_reg == S_CHK) && frame_good && cmd_illegal_i; // R20 R8
  assign set_vec[`CRS_B_ECC_FAIL] = ecc_fail_err_i; // R21
  assign set_vec[`CRS_B_CTRL] = controller_err_i; // R21
  assign set_vec[`CRS_B_GENERAL] = general_err_i; // R21
  assign set_vec[`CRS_B_RSV18] = 1'b0;
  assign set_vec[`CRS_B_RSV17] = 1'b0;
  assign set_vec[`CRS_B_SPEC_OVR] = specific_data_overwrite_err_i; // R22

  // Read clear is taken when a status is handed out, next clear on any legal command; the reply already holds the old value
  always @* begin
    clr_vec = 16'h0000;
    if (state_reg == S_CHK) begin
      if (send_r1) begin
        clr_vec = clr_vec | `CRS_CLR_READ_MASK; // R11
      end
      if (cmd_legal) begin
        clr_vec = clr_vec | `CRS_CLR_NEXT_MASK; // R10
      end
    end
  end

  // Set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_stat
      // Lock position copies the level, it never latches
      if (gi == `CRS_B_LOCKED) begin : g_lock
        assign stat_next[gi] = locked_flag_i; // R17
      end else if (gi == `CRS_B_RSV18 || gi == `CRS_B_RSV17) begin : g_rsv
        assign stat_next[gi] = 1'b0; // R23
      end else begin : g_flag
        // Reply and clear use the same stat_reg, so no event is lost
        assign stat_next[gi] = set_vec[gi] | (stat_reg[gi] & ~clr_vec[gi]);
      end
    end
  endgenerate

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_reg <= `CRS_STAT_RESET;
      card_status_word_o <= 32'h00000000;
    end else if (ce_i) begin
      stat_reg <= stat_next;
      card_status_word_o <= {stat_reg, status_lo_i}; // R6
    end
  end

  // CRC feed: receive covers the first 40 bits, transmit likewise
  always @* begin
    crc_step = 1'b0;
    crc_first = 1'b0;
    crc_bit = 1'b0;
    if (state_reg == S_IDLE && bclk_rise && !cmd_s2_reg) begin
      crc_step = 1'b1;
      crc_first = 1'b1;
    end else if (state_reg == S_RX && bclk_rise && cnt_inc < `CRS_CRC_FEED_END) begin
      crc_step = 1'b1;
      crc_bit = cmd_s2_reg;
    end else if (state_reg == S_WAIT && bclk_fall && gap_reg == `CRS_NCR_EDGES) begin
      crc_step = 1'b1;
      crc_first = 1'b1;
      crc_bit = sr_reg[47];
    end else if (state_reg == S_TX && bclk_fall && cnt_inc < `CRS_CRC_FEED_END) begin
      crc_step = 1'b1;
      crc_bit = sr_reg[46];
    end
  end

  crs_crc7 u_crc (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .step_i(crc_step),
    .first_i(crc_first),
    .bit_i(crc_bit),
    .crc_o(crc_val)
  );

  // Frame sequencer; host drives on falling edges, so the card samples on rising ones
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= S_IDLE;
      cnt_reg <= 6'd0;
      sr_reg <= 48'h000000000000;
      gap_reg <= 3'd0;
      cmd_o <= 1'b1;
      cmd_oe_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_index_o <= 6'd0;
      cmd_arg_o <= 32'h00000000;
    end else if (ce_i) begin
      cmd_valid_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (bclk_rise && !cmd_s2_reg) begin
            sr_reg <= 48'h000000000000;
            cnt_reg <= 6'd0;
            state_reg <= S_RX;
          end
        end
        S_RX: begin
          if (bclk_rise) begin
            sr_reg <= {sr_reg[46:0], cmd_s2_reg};
            cnt_reg <= cnt_inc;
            if (cnt_inc == `CRS_LAST_BIT) begin
              state_reg <= S_CHK;
            end
          end
        end
        S_CHK: begin
          gap_reg <= 3'd0;
          if (frame_good) begin
            cmd_valid_o <= 1'b1;
            cmd_index_o <= rx_index;
            cmd_arg_o <= rx_arg;
          end
          if (send_r7) begin
            sr_reg <= r7_frame; // R1
            state_reg <= S_WAIT;
          end else if (send_r1) begin
            sr_reg <= r1_frame; // R6
            state_reg <= S_WAIT;
          end else begin
            state_reg <= S_IDLE; // R3
          end
        end
        S_WAIT: begin
          if (bclk_fall) begin
            if (gap_reg == `CRS_NCR_EDGES) begin
              cmd_o <= sr_reg[47];
              cmd_oe_o <= 1'b1;
              cnt_reg <= 6'd0;
              state_reg <= S_TX;
            end else begin
              gap_reg <= gap_reg + 3'd1;
            end
          end
        end
        S_TX: begin
          if (bclk_fall) begin
            if (cnt_reg == `CRS_LAST_BIT) begin
              cmd_o <= 1'b1;
              cmd_oe_o <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              cnt_reg <= cnt_inc;
              if (cnt_inc == `CRS_CRC_FIRST) begin
                // CRC of bits 47..8 is complete here; end bit follows it
                cmd_o <= crc_val[6];
                sr_reg <= {1'b0, crc_val[5:0], 1'b1, 40'h0000000000};
              end else begin
                cmd_o <= sr_reg[46];
                sr_reg <= {sr_reg[46:0], 1'b0};
              end
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // crs_card_status

// ==== crs_card_status_asserts.sv ====
// Checker on the card status block ports.
// Assumes ce_i stays high in the bench.
module crs_card_status_asserts (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Command line
  input wire cmd_o,
  input wire cmd_oe_o,
  input wire cmd_valid_o,
  // Status
  input wire arg_range_err_i,
  input wire locked_flag_i,
  input wire [15:0] status_lo_i,
  input wire [31:0] card_status_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up;
  logic [9:0] hi_cnt;
  // Past values mean nothing until a few edges after reset
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up <= 2'd0;
      hi_cnt <= 10'd0;
    end else begin
      up <= (up == 2'd3) ? up : up + 2'd1;
      hi_cnt <= cmd_oe_o ? hi_cnt + 10'd1 : 10'd0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rsv; card_status_word_o[18:17] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_low; up == 2'd3 |-> card_status_word_o[15:0] == $past(status_lo_i); endproperty
  a_low: assert property (p_low) else $error("low half differs");
  property p_range; arg_range_err_i |-> ##2 card_status_word_o[31]; endproperty
  a_range: assert property (p_range) else $error("bit 31 not set");
  property p_lock;
    up == 2'd3 && $changed(locked_flag_i) |-> ##2 card_status_word_o[25] == $past(locked_flag_i, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("bit 25 lags lock");
  property p_head; $rose(cmd_oe_o) |-> (cmd_oe_o && !cmd_o) [*8]; endproperty
  a_head: assert property (p_head) else $error("reply head not low");
  property p_idle; !cmd_oe_o |-> cmd_o; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_valid; cmd_valid_o |=> !cmd_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("valid pulse too long");
  property p_len; $fell(cmd_oe_o) |-> hi_cnt >= 10'd382 && hi_cnt <= 10'd386; endproperty
  a_len: assert property (p_len) else $error("reply length wrong");
  c_reply: cover property ($rose(cmd_oe_o));
  c_lock: cover property ($rose(card_status_word_o[25]));
  c_valid: cover property (cmd_valid_o);
endmodule // crs_card_status_asserts

// ==== crs_host.sv ====
// Host on the card bus: clocks only during a transfer, sends a command, collects the reply.
// Assumes the bench pulls the released command line high.
module crs_host (
  // Card bus
  output logic bus_clk_o,
  output logic cmd_oe_o,
  output logic cmd_o,
  input wire logic cmd_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [47:0] sh;
  logic [47:0] rsp;
  event done;
  initial begin
    bus_clk_o = 1'b0;
    cmd_oe_o = 1'b0;
    cmd_o = 1'b1;
  end
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  // Sample mid-bit on the rise; the card moves the line after the fall
  task automatic tick();
    #80 bus_clk_o = 1'b1;
    sh = {sh[46:0], cmd_i};
    #80 bus_clk_o = 1'b0;
  endtask
  task automatic xfer(input logic [47:0] f, input int idle);
    bit got;
    cmd_oe_o = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      cmd_o = f[i];
      tick();
    end
    cmd_oe_o = 1'b0;
    sh = '1;
    for (int n = 0; n < 64 && sh[0]; n++) tick();
    got = !sh[0];
    if (got) repeat (47) tick();
    rsp = got ? sh : 48'h0;
    // Card lets go one fall after the end bit
    repeat (2) tick();
    -> done;
    #(idle * 160);
  endtask
endmodule // crs_host

// ==== crs_card_status_tb.sv ====
// Bench for the card status block: host model on the bus, events and lock driven here.
// Assumes the design, crs_host and the checker compile first.
module crs_card_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ill = 1'b0;
  logic lock = 1'b0;
  logic [15:0] lo = 16'h0000;
  logic [15:0] ev = 16'h0000;
  logic [15:0] m;
  logic [31:0] a = 32'h0;
  logic [47:0] e;
  logic [47:0] q[$];
  logic [3:0] codes[5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hf};
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  wire bclk, hoe, hbit, cmd_o, cmd_oe_o;
  wire [31:0] word;
  wire [5:0] idx;
  wire [31:0] arg;
  // Pull-up: a released line reads high
  wire line = cmd_oe_o ? cmd_o : (hoe ? hbit : 1'b1);
  crs_card_status crs_card_status_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .bus_clk_i(bclk), .cmd_i(line), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o), .cmd_illegal_i(ill),
    .status_lo_i(lo), .cmd_valid_o(), .cmd_index_o(idx), .cmd_arg_o(arg), .arg_range_err_i(ev[15]),
    .addr_err_i(ev[14]), .blk_length_err_i(ev[13]), .erase_order_err_i(ev[12]), .erase_select_err_i(ev[11]),
    .protected_write_err_i(ev[10]), .locked_flag_i(lock), .lock_fail_err_i(ev[8]), .ecc_fail_err_i(ev[5]),
    .controller_err_i(ev[4]), .general_err_i(ev[3]), .specific_data_overwrite_err_i(ev[0]),
    .card_status_word_o(word));
  crs_host crs_host_inst (.bus_clk_o(bclk), .cmd_oe_o(hoe), .cmd_o(hbit), .cmd_i(line));
  always #10 ref_clk_i = ~ref_clk_i;
  function automatic logic [47:0] fr(input logic [1:0] h, input logic [5:0] ix, input logic [31:0] d);
    return {h, ix, d, crs_host_inst.crc7({h, ix, d}), 1'b1};
  endfunction
  function automatic logic [47:0] r1(input logic [15:0] hi);
    return fr(2'b00, 6'd13, {hi | {6'h00, lock, 9'h000}, lo});
  endfunction
  task automatic cmd(input logic [5:0] ix, input logic bad, input logic [47:0] x);
    q.push_back(x);
    crs_host_inst.xfer(fr(2'b01, ix, a) ^ {46'h0, bad, 1'b0}, $urandom_range(3));
    if (!bad) begin
      checked++;
      if (idx !== ix || arg !== a) begin
        errors++;
        $display("BAD decode expected %h %h seen %h %h", ix, a, idx, arg);
      end
    end
  endtask
  task automatic pulse(input logic [15:0] v);
    @(negedge ref_clk_i);
    lock = 1'($urandom);
    lo = 16'($urandom);
    ev = v;
    @(negedge ref_clk_i);
    ev = 16'h0000;
  endtask
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial forever begin
    @(crs_host_inst.done);
    e = q.pop_front();
    checked++;
    if (crs_host_inst.rsp !== e) begin
      errors++;
      $display("BAD reply expected %h seen %h", e, crs_host_inst.rsp);
    end
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    void'($urandom(43));
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    a = $urandom;
    a[11:8] = 4'h1;
    cmd(6'h08, 1'b0, fr(2'b00, 6'h08, {20'h00000, a[11:0]}));
    foreach (codes[i]) begin
      a[11:8] = codes[i];
      cmd(6'h08, 1'b0, 48'h0);
    end
    for (int i = 0; i < 16; i++) begin
      m = 16'hfd39 & (16'h0001 << i);
      if (m != 16'h0000) begin
        pulse(m);
        @(negedge ref_clk_i);
        checked++;
        if (word !== {m | {6'h00, lock, 9'h000}, lo}) begin
          errors++;
          $display("BAD status expected %h seen %h", {m | {6'h00, lock, 9'h000}, lo}, word);
        end
        cmd(6'd13, 1'b0, r1(m));
      end
    end
    pulse(16'h0000);
    cmd(6'd13, 1'b0, r1(16'h0000));
    pulse(16'h8000);
    a[11:8] = 4'h1;
    cmd(6'h08, 1'b0, fr(2'b00, 6'h08, {20'h00000, a[11:0]}));
    cmd(6'd13, 1'b0, r1(16'h8000));
    cmd(6'd13, 1'b1, 48'h0);
    @(negedge ref_clk_i);
    ill = 1'b1;
    cmd(6'd13, 1'b0, 48'h0);
    @(negedge ref_clk_i);
    ill = 1'b0;
    cmd(6'd13, 1'b0, r1(16'h00c0));
    cmd(6'd13, 1'b0, r1(16'h0000));
    repeat (20) @(negedge ref_clk_i);
    final_report();
  end
endmodule // crs_card_status_tb

bind crs_card_status crs_card_status_asserts crs_card_status_asserts_inst (.ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o), .cmd_valid_o(cmd_valid_o),
  .arg_range_err_i(arg_range_err_i), .locked_flag_i(locked_flag_i), .status_lo_i(status_lo_i),
  .card_status_word_o(card_status_word_o));
